// ==== hw/lctmc_pkg.sv ====
// lctmc_pkg: constants for the linear ccd timing and mode control block
package lctmc_pkg;

    // ************************************************************
    // master clock and pixel timing
    // ************************************************************
    localparam int unsigned MASTER_PER_PIXEL = 10;
    localparam logic [3:0]  PH_LAST          = 4'h9;
    localparam logic [3:0]  PH_RESET_END     = 4'h2;
    localparam logic [3:0]  PH_CLAMP_END     = 4'h4;
    localparam logic [3:0]  PH_HALF          = 4'h5;
    localparam logic [3:0]  PH_SAMPLE_BEG    = 4'h6;
    localparam logic [3:0]  PH_SAMPLE_END    = 4'h8;

    // ************************************************************
    // line lengths per sensor setting, pixels per line
    // ************************************************************
    localparam int unsigned PIX_W = 15;
    localparam logic [PIX_W-1:0] LINE_LEN_0 = 15'd2872;
    localparam logic [PIX_W-1:0] LINE_LEN_1 = 15'd6372;
    localparam logic [PIX_W-1:0] LINE_LEN_2 = 15'd8572;
    localparam logic [PIX_W-1:0] LINE_LEN_3 = 15'd10372;
    localparam logic [PIX_W-1:0] LINE_LEN_4 = 15'd2472;
    localparam logic [PIX_W-1:0] LINE_LEN_5 = 15'd14972;
    localparam logic [PIX_W-1:0] LINE_LEN_6 = 15'd172;
    localparam logic [PIX_W-1:0] LINE_LEN_7 = 15'd14972;

    // ************************************************************
    // transfer gates, binning and exposure
    // ************************************************************
    localparam logic [PIX_W-1:0] TG1_WIDTH   = 15'd21;
    localparam logic [PIX_W-1:0] TG2_WIDTH   = 15'd26;
    localparam logic [1:0]       BIN1_LAST   = 2'h0;
    localparam logic [1:0]       TWO_PIXEL_BINNING_LAST   = 2'h1;
    localparam logic [1:0]       FOUR_PIXEL_BINNING_LAST   = 2'h3;
    localparam logic [PIX_W-1:0] EXPO_STEP   = 15'd500;
    localparam logic [3:0]       EXPO_NEVER  = 4'h0;
    localparam logic [3:0]       EXPO_ALWAYS = 4'hF;

    // ************************************************************
    // front-end serial programming
    // ************************************************************
    localparam int unsigned AFE_WORD_W   = 16;
    localparam logic [3:0]  AFE_BIT_LAST = 4'hF;
    localparam logic [2:0]  AFE_REG_LAST = 3'h7;
    localparam logic [3:0]  AFE_PAD      = 4'h0;
    localparam logic        AFE_WRITE    = 1'b0;
    // offsets 0..7: config, mux, gains r/g/b, offsets r/g/b
    localparam logic [7:0]  AFE_CFG_DEF  = 8'h32;
    localparam logic [7:0]  AFE_MUX_DEF  = 8'h09;
    localparam logic [7:0]  AFE_GAIN_DEF = 8'h00;
    localparam logic [7:0]  AFE_OFS_DEF  = 8'h00;
    localparam logic [63:0] AFE_DEFAULTS = {
        AFE_OFS_DEF, AFE_OFS_DEF, AFE_OFS_DEF,
        AFE_GAIN_DEF, AFE_GAIN_DEF, AFE_GAIN_DEF,
        AFE_MUX_DEF, AFE_CFG_DEF};

    // serial loader states
    typedef enum logic [3:0] {
        LCTMC_IDLE  = 4'b0001,
        LCTMC_LOAD  = 4'b0010,
        LCTMC_SHIFT = 4'b0100,
        LCTMC_DONE  = 4'b1000
    } lctmc_state_e;

endpackage

// ==== hw/lctmc_top.sv ====
// lctmc_top: tri-linear ccd timing generator and front-end loader
`timescale 1ns/1ps
// ************************************************************
// What this block does
// - sensor switch selects one of seven line lengths (settings 5 and 7 equal)
// - no binning resets output node every pixel
// - two-pixel binning resets every second pixel
// - four-pixel binning resets every fourth pixel
// - binning slows reset, clamp, sample, converter, pixel sync
// - integration switch gives one to four lines
// - separate green and red exposure settings
// - exposure zero low, one to fourteen 500 pixels per step
// - exposure fifteen high except transfer-gate period
// - first transfer gate is 21 pixels wide
// - second transfer gate is 26 pixels wide
// - phase clocks from sensor; gates mode independent
// - master clock on-board or external by select
// - config and mux defaults with fixed test bits
// - internal mode writes defaults after every reset
// - gain and offset codes keep documented meaning
// ************************************************************
module lctmc_top
    import lctmc_pkg::*;
(
    // clock, reset, enable
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic       clk_en,
    // mode switches and jumpers (pins)
    input  wire logic [2:0] line_length_select_switch,
    input  wire logic       two_pixel_binning,
    input  wire logic       four_pixel_binning,
    input  wire logic [2:0] integration_select_switch,
    input  wire logic [3:0] green_exposure_switch,
    input  wire logic [3:0] red_exposure_switch,
    // master clock source (pins)
    input  wire logic       external_clock_select,
    input  wire logic       external_master_clock,
    // front-end programming source (pins)
    input  wire logic       external_program_select,
    input  wire logic       ext_serial_clock,
    input  wire logic       ext_serial_data,
    input  wire logic       ext_red_load_n,
    input  wire logic       ext_green_load_n,
    input  wire logic       ext_blue_load_n,
    // sensor clocks
    output logic            phase_one,
    output logic            phase_two,
    output logic            reset_gate,
    output logic            transfer_gate_one,
    output logic            transfer_gate_two,
    output logic            green_overflow_gate,
    output logic            red_overflow_gate,
    // converter and frame grabber syncs
    output logic            clamp,
    output logic            sample,
    output logic            converter_clock,
    output logic            pixel_sync,
    output logic            line_sync,
    output logic            frame_sync,
    // front-end serial link
    output logic            afe_serial_clock,
    output logic            afe_serial_data,
    output logic            red_serial_load_enable_n,
    output logic            green_serial_load_enable_n,
    output logic            blue_serial_load_enable_n,
    output logic            afe_program_busy
);
    import lctmc_pkg::*;

    // ************************************************************
    // pin synchronisers
    // ************************************************************
    localparam int unsigned SYNC_W = 24;
    logic [SYNC_W-1:0] pin_raw;
    logic [SYNC_W-1:0] sync1_q;
    logic [SYNC_W-1:0] sync2_q;
    logic              mclk_prev_q;

    assign pin_raw = {line_length_select_switch, two_pixel_binning,
                      four_pixel_binning, integration_select_switch,
                      green_exposure_switch, red_exposure_switch,
                      external_clock_select, external_master_clock,
                      external_program_select, ext_serial_clock,
                      ext_serial_data, ext_red_load_n,
                      ext_green_load_n, ext_blue_load_n};

    // two flops per pin; only the second is read
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else if (clk_en) begin
            sync1_q <= pin_raw;
            sync2_q <= sync1_q;
        end
    end

    logic [2:0] sel_len;
    logic       sel_two_pixel_binning;
    logic       sel_four_pixel_binning;
    logic [2:0] sel_integ;
    logic [3:0] sel_gexp;
    logic [3:0] sel_rexp;
    logic       ext_clk_sel;
    logic       ext_mclk;
    logic       ext_prog_sel;
    logic [4:0] ext_serial;

    assign {sel_len, sel_two_pixel_binning, sel_four_pixel_binning, sel_integ, sel_gexp, sel_rexp,
            ext_clk_sel, ext_mclk, ext_prog_sel, ext_serial} = sync2_q;

    // ************************************************************
    // decode helpers
    // ************************************************************
    function automatic logic [PIX_W-1:0] line_len_of(logic [2:0] s);
        logic [PIX_W-1:0] r;
        r = LINE_LEN_0;
        unique case (s)
            3'h0: r = LINE_LEN_0;
            3'h1: r = LINE_LEN_1;
            3'h2: r = LINE_LEN_2;
            3'h3: r = LINE_LEN_3;
            3'h4: r = LINE_LEN_4;
            3'h5: r = LINE_LEN_5;
            3'h6: r = LINE_LEN_6;
            3'h7: r = LINE_LEN_7;
        endcase
        return r;
    endfunction

    // overflow gate level for one colour
    function automatic logic expo_on(logic [3:0] code,
                                     logic [PIX_W-1:0] pix,
                                     logic tg_period);
        logic [PIX_W-1:0] span;
        span = PIX_W'(code) * EXPO_STEP;
        if (code == EXPO_NEVER)
            return 1'b0;
        else if (code == EXPO_ALWAYS)
            return !tg_period;
        else
            return pix < span;
    endfunction

    // ************************************************************
    // master tick and pixel phase
    // ************************************************************
    logic       master_tick;
    logic       pix_tick;
    logic [3:0] ph_q;

    // external master clock counts on its rising edge; on-board is clk
    assign master_tick = clk_en && (ext_clk_sel ? (ext_mclk && !mclk_prev_q)
                                                : 1'b1);
    assign pix_tick    = master_tick && (ph_q == PH_LAST);

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            mclk_prev_q <= 1'b0;
            ph_q        <= 4'h0;
        end else if (clk_en) begin
            mclk_prev_q <= ext_mclk;
            if (master_tick)
                ph_q <= pix_tick ? 4'h0 : ph_q + 4'h1;
        end
    end

    // ************************************************************
    // line, binning and integration counters
    // ************************************************************
    logic [PIX_W-1:0] pix_cnt_q;
    logic [PIX_W-1:0] len_q;
    logic [1:0]       bin_last_q;
    logic [1:0]       bin_cnt_q;
    logic [1:0]       integ_q;
    logic [1:0]       line_cnt_q;
    logic [3:0]       gexp_q;
    logic [3:0]       rexp_q;
    logic             xfer_q;
    logic             line_end;
    logic             xfer_next;
    logic [1:0]       bin_last_d;

    assign line_end   = pix_tick && (pix_cnt_q == len_q - 15'd1);
    assign xfer_next  = (line_cnt_q == integ_q);
    assign bin_last_d = sel_four_pixel_binning ? FOUR_PIXEL_BINNING_LAST :
                        sel_two_pixel_binning ? TWO_PIXEL_BINNING_LAST : BIN1_LAST;

    // settings only change at the line boundary
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pix_cnt_q  <= '0;
            len_q      <= LINE_LEN_0;
            bin_last_q <= BIN1_LAST;
            bin_cnt_q  <= 2'h0;
            integ_q    <= 2'h0;
            line_cnt_q <= 2'h0;
            gexp_q     <= EXPO_NEVER;
            rexp_q     <= EXPO_NEVER;
            xfer_q     <= 1'b1;
        end else if (line_end) begin
            pix_cnt_q  <= '0;
            len_q      <= line_len_of(sel_len);
            bin_last_q <= bin_last_d;
            bin_cnt_q  <= 2'h0;
            integ_q    <= sel_integ[1:0];
            gexp_q     <= sel_gexp;
            rexp_q     <= sel_rexp;
            xfer_q     <= xfer_next;
            line_cnt_q <= xfer_next ? 2'h0 : line_cnt_q + 2'h1;
        end else if (pix_tick) begin
            pix_cnt_q <= pix_cnt_q + 15'd1;
            bin_cnt_q <= (bin_cnt_q == bin_last_q) ? 2'h0
                                                   : bin_cnt_q + 2'h1;
        end
    end

    // ************************************************************
    // waveform decode
    // ************************************************************
    logic tg1_win;
    logic tg2_win;
    logic grp_last;
    logic rg_now;
    logic g_on;
    logic r_on;

    // transfer gates do not depend on binning or sensor mode
    assign tg1_win  = xfer_q && (pix_cnt_q < TG1_WIDTH);
    assign tg2_win  = xfer_q && (pix_cnt_q < TG2_WIDTH);
    assign grp_last = (bin_cnt_q == bin_last_q);
    assign rg_now   = grp_last && (ph_q < PH_RESET_END);
    assign g_on     = expo_on(gexp_q, pix_cnt_q, tg2_win);
    assign r_on     = expo_on(rexp_q, pix_cnt_q, tg2_win);

    // timing outputs from flops
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            {phase_one, phase_two, reset_gate, clamp, sample} <= '0;
            {converter_clock, pixel_sync, line_sync}          <= '0;
            {frame_sync, transfer_gate_one, transfer_gate_two} <= '0;
            {green_overflow_gate, red_overflow_gate}           <= '0;
        end else if (clk_en) begin
            phase_one  <= (ph_q < PH_HALF);
            phase_two  <= !(ph_q < PH_HALF);
            reset_gate <= rg_now;
            clamp      <= grp_last && (ph_q >= PH_RESET_END)
                          && (ph_q < PH_CLAMP_END);
            sample     <= grp_last && (ph_q >= PH_SAMPLE_BEG)
                          && (ph_q < PH_SAMPLE_END);
            converter_clock     <= grp_last && (ph_q >= PH_HALF);
            pixel_sync          <= grp_last && (ph_q < PH_HALF);
            line_sync           <= (pix_cnt_q == '0);
            frame_sync          <= tg2_win;
            transfer_gate_one   <= tg1_win;
            transfer_gate_two   <= tg2_win;
            green_overflow_gate <= g_on;
            red_overflow_gate   <= r_on;
        end
    end

    // ************************************************************
    // front-end default loader
    // ************************************************************
    lctmc_state_e           state_q;
    logic                   pending_q;
    logic [2:0]             reg_idx_q;
    logic [3:0]             bit_q;
    logic [AFE_WORD_W-1:0]  word_q;
    logic                   sck_q;
    logic                   load_n_q;
    logic [7:0]             def_byte;

    assign def_byte = AFE_DEFAULTS[{reg_idx_q, 3'h0} +: 8];

    // pending is set by reset so every reset reloads the defaults
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_q   <= LCTMC_IDLE;
            pending_q <= 1'b1;
            reg_idx_q <= 3'h0;
            bit_q     <= 4'h0;
            word_q    <= '0;
            sck_q     <= 1'b0;
            load_n_q  <= 1'b1;
        end else if (clk_en) begin
            unique case (state_q)
                LCTMC_IDLE: begin
                    reg_idx_q <= 3'h0;
                    if (pending_q && !ext_prog_sel)
                        state_q <= LCTMC_LOAD;
                end
                LCTMC_LOAD: begin
                    word_q   <= {AFE_WRITE, reg_idx_q, AFE_PAD, def_byte};
                    bit_q    <= AFE_BIT_LAST;
                    load_n_q <= 1'b0;
                    sck_q    <= 1'b0;
                    state_q  <= LCTMC_SHIFT;
                end
                LCTMC_SHIFT: begin
                    sck_q <= !sck_q;
                    if (sck_q) begin
                        word_q <= {word_q[AFE_WORD_W-2:0], 1'b0};
                        bit_q  <= bit_q - 4'h1;
                        if (bit_q == 4'h0) begin
                            load_n_q  <= 1'b1;
                            reg_idx_q <= reg_idx_q + 3'h1;
                            state_q   <= (reg_idx_q == AFE_REG_LAST)
                                         ? LCTMC_DONE : LCTMC_LOAD;
                        end
                    end
                end
                LCTMC_DONE: begin
                    pending_q <= 1'b0;
                    state_q   <= LCTMC_IDLE;
                end
            endcase
        end
    end

    // external mode hands the lines to the remote controller
    assign afe_serial_clock = ext_prog_sel ? ext_serial[4] : sck_q;
    assign afe_serial_data  = ext_prog_sel ? ext_serial[3]
                                           : word_q[AFE_WORD_W-1];
    assign red_serial_load_enable_n   = ext_prog_sel ? ext_serial[2]
                                                     : load_n_q;
    assign green_serial_load_enable_n = ext_prog_sel ? ext_serial[1]
                                                     : load_n_q;
    assign blue_serial_load_enable_n  = ext_prog_sel ? ext_serial[0]
                                                     : load_n_q;
    assign afe_program_busy = (state_q != LCTMC_IDLE);

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    sequence gate_one_ends;
        $fell(tg1_win);
    endsequence
    sequence gate_two_ends;
        $fell(tg2_win);
    endsequence

    tg1_width_a: assert property (gate_one_ends |->
        pix_cnt_q == TG1_WIDTH && xfer_q) else $error("gate one width");
    tg2_width_a: assert property (gate_two_ends |->
        pix_cnt_q == TG2_WIDTH && xfer_q) else $error("gate two width");
    line_wrap_a: assert property (line_end |=> pix_cnt_q == '0
        && len_q == $past(line_len_of(sel_len)))
        else $error("line did not wrap at length");
    bin_reset_a: assert property (rg_now |->
        (pix_cnt_q[1:0] & bin_last_q) == bin_last_q)
        else $error("reset gate inside a binning group");
    xfer_count_a: assert property ($rose(xfer_q) |->
        $past(line_cnt_q) == $past(integ_q))
        else $error("transfer at wrong line count");
    expo_zero_a: assert property (gexp_q == EXPO_NEVER |-> !g_on)
        else $error("green gate high at setting zero");
    expo_full_a: assert property (rexp_q == EXPO_ALWAYS |->
        r_on == !tg2_win) else $error("red gate not low in gate");
    prog_word_a: assert property (state_q == LCTMC_LOAD && clk_en |=>
        state_q == LCTMC_SHIFT && word_q[7:0] == $past(def_byte)
        && !load_n_q) else $error("default word not loaded");
endmodule

// ==== sim/lctmc_afe_model.sv ====
// lctmc_afe_model: three front-end converters seen over the serial link
`timescale 1ns/1ps
module lctmc_afe_model (
    // serial link from the block
    input wire logic       sck,
    input wire logic       sdata,
    input wire logic [2:0] load_n
);
    // ************************************************************
    // register files, one per colour channel
    // ************************************************************
    logic [7:0]  regs  [3][8];
    logic [15:0] shreg [3];

    // every register starts at a marker so a missed write shows
    initial begin
        for (int c = 0; c < 3; c++) begin
            for (int a = 0; a < 8; a++) begin
                regs[c][a] = 8'hA5;
            end
        end
    end

    // shift on sck rise, commit a write word when load ends
    for (genvar c = 0; c < 3; c++) begin : g_ch
        always @(posedge sck) begin
            if (!load_n[c]) begin
                shreg[c] <= {shreg[c][14:0], sdata};
            end
        end
        always @(posedge load_n[c]) begin
            if (shreg[c][15] === 1'b0) begin
                regs[c][shreg[c][14:12]] <= shreg[c][7:0];
            end
        end
    end
endmodule

// ==== sim/lctmc_top_bench.sv ====
// lctmc_top_bench: self-checking bench for the ccd timing generator
`timescale 1ns/1ps
module lctmc_top_bench;
    logic clk, resetn, clk_en, two_pixel_binning, four_pixel_binning;
    logic external_clock_select, external_master_clock;
    logic external_program_select, ext_serial_clock, ext_serial_data;
    logic ext_red_load_n, ext_green_load_n, ext_blue_load_n;
    logic [2:0] line_length_select_switch, integration_select_switch;
    logic [3:0] green_exposure_switch, red_exposure_switch;
    logic phase_one, phase_two, reset_gate, transfer_gate_one;
    logic transfer_gate_two, green_overflow_gate, red_overflow_gate;
    logic clamp, sample, converter_clock, pixel_sync, line_sync;
    logic frame_sync, afe_serial_clock, afe_serial_data, afe_program_busy;
    logic red_serial_load_enable_n, green_serial_load_enable_n;
    logic blue_serial_load_enable_n;
    int num_errors, check_count, m_len, m_rg, m_ps, m_gh, m_rh, m_t1, m_t2;
    int m_ph, m_cl, m_sa, m_cv, m_fs;
    logic p_ls, p_rg, p_ps, ls_rise, rg_rise, ps_rise;
    logic [1:0] ext_div;

    lctmc_top i_lctmc_top (.clk(clk), .resetn(resetn), .clk_en(clk_en),
        .line_length_select_switch(line_length_select_switch),
        .two_pixel_binning(two_pixel_binning),
        .four_pixel_binning(four_pixel_binning),
        .integration_select_switch(integration_select_switch),
        .green_exposure_switch(green_exposure_switch),
        .red_exposure_switch(red_exposure_switch),
        .external_clock_select(external_clock_select),
        .external_master_clock(external_master_clock),
        .external_program_select(external_program_select),
        .ext_serial_clock(ext_serial_clock),
        .ext_serial_data(ext_serial_data), .ext_red_load_n(ext_red_load_n),
        .ext_green_load_n(ext_green_load_n),
        .ext_blue_load_n(ext_blue_load_n), .phase_one(phase_one),
        .phase_two(phase_two), .reset_gate(reset_gate),
        .transfer_gate_one(transfer_gate_one),
        .transfer_gate_two(transfer_gate_two),
        .green_overflow_gate(green_overflow_gate),
        .red_overflow_gate(red_overflow_gate), .clamp(clamp),
        .sample(sample), .converter_clock(converter_clock),
        .pixel_sync(pixel_sync), .line_sync(line_sync),
        .frame_sync(frame_sync), .afe_serial_clock(afe_serial_clock),
        .afe_serial_data(afe_serial_data),
        .red_serial_load_enable_n(red_serial_load_enable_n),
        .green_serial_load_enable_n(green_serial_load_enable_n),
        .blue_serial_load_enable_n(blue_serial_load_enable_n),
        .afe_program_busy(afe_program_busy));

    lctmc_afe_model i_lctmc_afe_model (.sck(afe_serial_clock),
        .sdata(afe_serial_data), .load_n({blue_serial_load_enable_n,
        green_serial_load_enable_n, red_serial_load_enable_n}));

    // ************************************************************
    // clock, slow external master clock, shared tasks
    // ************************************************************
    always #20 clk = ~clk;

    // external master clock at a quarter of clk
    always @(negedge clk) begin
        ext_div <= ext_div + 2'h1;
        external_master_clock <= ext_div[1];
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    // one falling edge, with edge detection on the outputs
    task automatic step;
        @(negedge clk);
        ls_rise = line_sync && !p_ls;
        rg_rise = reset_gate && !p_rg;
        ps_rise = pixel_sync && !p_ps;
        p_ls = line_sync;
        p_rg = reset_gate;
        p_ps = pixel_sync;
    endtask

    task automatic wait_line;
        int n;
        n = 0;
        do begin
            step;
            n++;
        end while (!ls_rise && n < 40000);
        if (n >= 40000) begin
            num_errors++;
        end
    endtask

    // measure one line from line-sync rise to the next; skip = 0 takes
    // the line that starts now
    task automatic measure(input bit skip = 1'b1);
        {m_len, m_rg, m_ps, m_gh, m_rh, m_t1, m_t2} = '0;
        {m_ph, m_cl, m_sa, m_cv, m_fs} = '0;
        if (skip) begin
            wait_line;
        end
        do begin
            m_len++;
            m_ph += int'(phase_one === 1'b1 && phase_two === 1'b0);
            m_cl += int'(clamp === 1'b1);
            m_sa += int'(sample === 1'b1);
            m_cv += int'(converter_clock === 1'b1);
            m_fs += int'(frame_sync === 1'b1);
            m_rg += int'(rg_rise);
            m_ps += int'(ps_rise);
            m_gh += int'(green_overflow_gate === 1'b1);
            m_rh += int'(red_overflow_gate === 1'b1);
            m_t1 += int'(transfer_gate_one === 1'b1);
            m_t2 += int'(transfer_gate_two === 1'b1);
            step;
        end while (!ls_rise && m_len < 40000);
    endtask

    task automatic results;
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic afe_defaults;
        int n;
        n = 0;
        do begin
            step;
            n++;
        end while (afe_program_busy !== 1'b0 && n < 1000);
        for (int c = 0; c < 3; c++) begin
            check(i_lctmc_afe_model.regs[c][0], 8'h32);
            check(i_lctmc_afe_model.regs[c][1], 8'h09);
            for (int a = 2; a < 8; a++) begin
                check(i_lctmc_afe_model.regs[c][a], 8'h00);
            end
        end
        check(n, 8 * 33 + 2);
    endtask

    task automatic line_basic;
        measure;
        check(m_len, 1720);
        check(m_rg, 172);
        check(m_ps, 172);
        check(m_t1, 210);
        check(m_t2, 260);
        check(m_gh, 1460);
        check(m_rh, 0);
        check(m_ph, 860);
        check(m_cl, 344);
        check(m_sa, 344);
        check(m_cv, 860);
        check(m_fs, 260);
    endtask

    task automatic binning(input logic two, input logic four, int groups);
        two_pixel_binning = two;
        four_pixel_binning = four;
        measure;
        check(m_rg, groups);
        check(m_ps, groups);
        check(m_cl, groups * 2);
        check(m_sa, groups * 2);
        check(m_cv, groups * 5);
        check(m_ph, 860);
        check(m_t1, 210);
        check(m_len, 1720);
    endtask

    task automatic integration_two;
        int a;
        integration_select_switch = 3'h5;
        wait_line;
        measure;
        a = m_t1;
        measure(1'b0);
        check(a + m_t1, 210);
        check(a * m_t1, 0);
        integration_select_switch = 3'h0;
    endtask

    task automatic ext_clock;
        external_clock_select = 1'b1;
        measure;
        check(m_len, 6880);
        external_clock_select = 1'b0;
    endtask

    task automatic remote_write(input logic [15:0] w);
        external_program_select = 1'b1;
        repeat (4) step;
        ext_green_load_n = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            ext_serial_data = w[i];
            repeat (4) step;
            ext_serial_clock = 1'b1;
            repeat (4) step;
            ext_serial_clock = 1'b0;
        end
        repeat (4) step;
        ext_green_load_n = 1'b1;
        repeat (8) step;
        check(i_lctmc_afe_model.regs[1][3], 8'h2A);
        check(i_lctmc_afe_model.regs[0][3], 8'h00);
    endtask

    task automatic exposure_long;
        wait_line;
        line_length_select_switch = 3'h4;
        green_exposure_switch = 4'h2;
        red_exposure_switch = 4'h1;
        measure;
        check(m_len, 24720);
        check(m_gh, 10000);
        check(m_rh, 5000);
    endtask

    // mid-run reset must load the defaults again
    task automatic reset_reload;
        external_program_select = 1'b0;
        resetn = 1'b0;
        repeat (4) step;
        resetn = 1'b1;
        afe_defaults;
    endtask

    // watchdog against a hang, about 100000 clocks
    initial begin
        #4000000;
        num_errors++;
        results;
    end

    // main sequence
    initial begin
        {clk, clk_en, resetn, two_pixel_binning, four_pixel_binning} = 5'h08;
        {external_clock_select, external_master_clock, ext_div} = '0;
        {external_program_select, ext_serial_clock, ext_serial_data} = '0;
        {ext_red_load_n, ext_green_load_n, ext_blue_load_n} = 3'h7;
        {p_ls, p_rg, p_ps} = '0;
        line_length_select_switch = 3'h6;
        integration_select_switch = 3'h0;
        green_exposure_switch = 4'hF;
        red_exposure_switch = 4'h0;
        repeat (4) @(negedge clk);
        resetn = 1'b1;
        afe_defaults;
        wait_line;
        line_basic;
        binning(1'b1, 1'b0, 43 * 2);
        binning(1'b1, 1'b1, 43);
        binning(1'b0, 1'b0, 172);
        integration_two;
        ext_clock;
        remote_write({1'b0, 3'h3, 4'h0, 8'h2A});
        exposure_long;
        reset_reload;
        results;
    end
endmodule
